// file: rtl/capacity_flags_defs.svh
/*
 * Constants of the capacity warning flags and load model block: field
 * positions, reset values, load choice codes and filter timing.
 * Assumes inclusion by the package and by every design module.
 */
`ifndef CAPACITY_FLAGS_DEFS_SVH
`define CAPACITY_FLAGS_DEFS_SVH

// ****************************************
// Data widths
// ****************************************
`define VAL_W 16
`define LOAD_W 32
`define ACC_W 32

// ****************************************
// Flags word bit positions
// ****************************************
`define FLAG_SOC_WARN_FINAL_FLAG_BIT 0
`define FLAG_SOC_WARN_INITIAL_FLAG_BIT 1
`define FLAG_TDD_BIT 2
`define FLAG_ISD_BIT 3
`define FLAGS_W 4

// ****************************************
// Thresholds and family codes
// ****************************************
`define SOC_WARN_FINAL_FLAG_SET_OFF 16'hffff
`define FAMILY_CURRENT 1'h0
`define FAMILY_POWER 1'h1

// ****************************************
// Load choice codes
// ****************************************
`define LSEL_PREV 3'h0
`define LSEL_PRESENT 3'h1
`define LSEL_MEAN 3'h2
`define LSEL_FILT 3'h3
`define LSEL_DESIGN 3'h4
`define LSEL_OVERRIDE 3'h5
`define LSEL_USER 3'h6
`define LSEL_CURRENT_DEF 3'h1
`define LSEL_POWER_DEF 3'h0
`define DESIGN_DIVISOR 5

// ****************************************
// Low-pass filter timing
// ****************************************
`define FILT_TAU_S 14
`define FILT_SAMPLE_S 1
`define FILT_TAU_SAMPLES (`FILT_TAU_S / `FILT_SAMPLE_S)

// ****************************************
// Reset values
// ****************************************
`define RST_FLAG 1'h0
`define RST_VAL 16'h0000
`define RST_LOAD 32'h00000000
`define RST_ACC 32'h00000000

`endif

// file: rtl/capacity_flags_pkg.sv
/*
 * Types of the capacity warning flags and load model block.
 * Assumes the defs header sits beside it on the include path.
 */
`include "capacity_flags_defs.svh"

package capacity_flags_pkg;

	// ****************************************
	// State records
	// ****************************************
	typedef struct packed {
		logic flag;
	} hyst_state_t;

	typedef struct packed {
		logic signed [`VAL_W-1:0] level;
	} filt_state_t;

	typedef struct packed {
		logic internalShort;
		logic tabDisconnect;
		logic loadFamily;
		logic signed [`LOAD_W-1:0] load;
		logic signed [`LOAD_W-1:0] reserveRate;
		logic signed [`ACC_W-1:0] chargeAccum;
		logic [`VAL_W-1:0] nominalAvail;
		logic [`VAL_W-1:0] fullAvail;
	} top_state_t;

endpackage : capacity_flags_pkg

// file: rtl/hyst_flag.sv
/*
 * One state-of-charge warning flag with separate set and clear levels.
 * Assumes value and thresholds are stable on the clock and update is a
 * single-cycle strobe marking a fresh remaining-charge value.
 */
`timescale 1ns/1ps
`include "capacity_flags_defs.svh"

module hyst_flag (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic update,
	input wire logic signed [`VAL_W-1:0] value,
	input wire logic signed [`VAL_W-1:0] setThr,
	input wire logic signed [`VAL_W-1:0] clrThr,
	input wire logic setEnable,
	output logic flag
);
	import capacity_flags_pkg::*;

	hyst_state_t st_r;
	hyst_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (update) begin
			// Set checked first so a misprogrammed overlap keeps warning
			if (setEnable && (value < setThr)) begin
				st_nxt.flag = 1'b1;
			end else if (st_r.flag && (value > clrThr)) begin
				st_nxt.flag = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{flag: `RST_FLAG};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag = st_r.flag;

endmodule : hyst_flag

// file: rtl/lowpass_mean.sv
/*
 * First-order low-pass of the mean current, one step per sample strobe.
 * Assumes the strobe arrives once per filter sample period.
 */
`timescale 1ns/1ps
`include "capacity_flags_defs.svh"

module lowpass_mean (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sampleValid,
	input wire logic signed [`VAL_W-1:0] sampleIn,
	output logic signed [`VAL_W-1:0] filtOut
);
	import capacity_flags_pkg::*;

	filt_state_t st_r;
	filt_state_t st_nxt;
	logic signed [`VAL_W:0] diff;
	logic signed [`VAL_W:0] step;

	always_comb begin
		st_nxt = st_r;
		diff = {sampleIn[`VAL_W-1], sampleIn} - {st_r.level[`VAL_W-1], st_r.level};
		// Truncating divide: small residue stays, traded for no extra bits
		step = diff / (`VAL_W+1)'(`FILT_TAU_SAMPLES);
		if (sampleValid) begin
			st_nxt.level = st_r.level + step[`VAL_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{level: `RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign filtOut = st_r.level;

endmodule : lowpass_mean

// file: rtl/capacity_flags_load_model.sv
/*
 * Capacity warning flags, short and tab-loss flags, load model choice,
 * reserve compensation rate and charge accumulation of a fuel gauge.
 * Assumes all inputs come from gauge logic on the same clock; strobes
 * are single-cycle pulses.
 */
`timescale 1ns/1ps
`include "capacity_flags_defs.svh"

module capacity_flags_load_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic remUpdate,
	input wire logic signed [`VAL_W-1:0] remainingChargeValue,
	input wire logic signed [`VAL_W-1:0] soc1SetThr,
	input wire logic signed [`VAL_W-1:0] soc1ClearThr,
	input wire logic signed [`VAL_W-1:0] socfSetThr,
	input wire logic signed [`VAL_W-1:0] socfClearThr,
	input wire logic shortDetect,
	input wire logic tabLossDetect,
	input wire logic loadMode,
	input wire logic [2:0] loadSelect,
	input wire logic signed [`VAL_W-1:0] prevAvgCurrent,
	input wire logic signed [`VAL_W-1:0] presentAvgCurrent,
	input wire logic meanUpdate,
	input wire logic signed [`VAL_W-1:0] meanCurrentValue,
	input wire logic [`VAL_W-1:0] voltage,
	input wire logic signed [`VAL_W-1:0] prevAvgPower,
	input wire logic signed [`VAL_W-1:0] presentAvgPower,
	input wire logic [`VAL_W-1:0] designCapacity,
	input wire logic [`VAL_W-1:0] designEnergy,
	input wire logic signed [`VAL_W-1:0] rateOverrideValue,
	input wire logic signed [`VAL_W-1:0] userCurrentRate,
	input wire logic signed [`VAL_W-1:0] userPowerRate,
	input wire logic reserveRateSelectBit,
	input wire logic [`VAL_W-1:0] reserveChargeAmount,
	input wire logic senseValid,
	input wire logic signed [`VAL_W-1:0] senseCharge,
	input wire logic [`VAL_W-1:0] chemCapacity,
	output logic socWarnInitialFlag,
	output logic socWarnFinalFlag,
	output logic internalShortFlag,
	output logic tabDisconnectFlag,
	output logic [`FLAGS_W-1:0] flagsWord,
	output logic loadFamilyStatusBit,
	output logic signed [`LOAD_W-1:0] selectedLoad,
	output logic signed [`LOAD_W-1:0] reserveCompRate,
	output logic [`VAL_W-1:0] reserveChargeOut,
	output logic signed [`ACC_W-1:0] chargeAccum,
	output logic [`VAL_W-1:0] nominalAvailValue,
	output logic [`VAL_W-1:0] fullAvailValue
);
	import capacity_flags_pkg::*;

	top_state_t st_r;
	top_state_t st_nxt;
	logic signed [`VAL_W-1:0] filtCurrent;
	logic signed [`LOAD_W-1:0] loadPick;
	logic signed [`ACC_W-1:0] accSum;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic signed [`LOAD_W-1:0] widen(input logic signed [`VAL_W-1:0] v);
		widen = `LOAD_W'(v);
	endfunction : widen

	function automatic logic signed [`LOAD_W-1:0] ivProduct(
		input logic signed [`VAL_W-1:0] i,
		input logic [`VAL_W-1:0] v);
		logic signed [`LOAD_W:0] p;
		p = $signed({{(`LOAD_W-`VAL_W+1){i[`VAL_W-1]}}, i}) * $signed({1'b0, `LOAD_W'(v)});
		ivProduct = p[`LOAD_W-1:0];
	endfunction : ivProduct

	function automatic logic signed [`LOAD_W-1:0] fifth(input logic [`VAL_W-1:0] d);
		fifth = $signed(`LOAD_W'(d / `VAL_W'(`DESIGN_DIVISOR)));
	endfunction : fifth

	function automatic logic [`VAL_W-1:0] clampVal(input logic signed [`ACC_W-1:0] a);
		if (a < 0) begin
			clampVal = `RST_VAL;
		end else if (a > $signed(`ACC_W'({`VAL_W{1'b1}}))) begin
			clampVal = {`VAL_W{1'b1}};
		end else begin
			clampVal = a[`VAL_W-1:0];
		end
	endfunction : clampVal

	// ****************************************
	// Warning flags with hysteresis
	// ****************************************
	// Evaluated only on the update strobe so flags track the fresh value
	hyst_flag u_socInitial (
		.clk(clk),
		.rst_n(rst_n),
		.update(remUpdate),
		.value(remainingChargeValue),
		.setThr(soc1SetThr),
		.clrThr(soc1ClearThr),
		.setEnable(1'b1),
		.flag(socWarnInitialFlag)
	);

	hyst_flag u_socFinal (
		.clk(clk),
		.rst_n(rst_n),
		.update(remUpdate),
		.value(remainingChargeValue),
		.setThr(socfSetThr),
		.clrThr(socfClearThr),
		.setEnable(socfSetThr != $signed(`SOC_WARN_FINAL_FLAG_SET_OFF)),
		.flag(socWarnFinalFlag)
	);

	// ****************************************
	// Filtered mean current
	// ****************************************
	lowpass_mean u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.sampleValid(meanUpdate),
		.sampleIn(meanCurrentValue),
		.filtOut(filtCurrent)
	);

	// ****************************************
	// Load model choice
	// ****************************************
	always_comb begin
		loadPick = widen(presentAvgCurrent);
		if (loadMode == `FAMILY_CURRENT) begin
			case (loadSelect)
				`LSEL_PREV: loadPick = widen(prevAvgCurrent);
				`LSEL_PRESENT: loadPick = widen(presentAvgCurrent);
				`LSEL_MEAN: loadPick = widen(meanCurrentValue);
				`LSEL_FILT: loadPick = widen(filtCurrent);
				`LSEL_DESIGN: loadPick = fifth(designCapacity);
				`LSEL_OVERRIDE: loadPick = widen(rateOverrideValue);
				`LSEL_USER: loadPick = widen(userCurrentRate);
				// Unused code falls back to the family default
				default: loadPick = widen(presentAvgCurrent);
			endcase
		end else begin
			case (loadSelect)
				`LSEL_PREV: loadPick = widen(prevAvgPower);
				`LSEL_PRESENT: loadPick = widen(presentAvgPower);
				`LSEL_MEAN: loadPick = ivProduct(meanCurrentValue, voltage);
				`LSEL_FILT: loadPick = ivProduct(filtCurrent, voltage);
				`LSEL_DESIGN: loadPick = fifth(designEnergy);
				`LSEL_OVERRIDE: loadPick = widen(rateOverrideValue);
				`LSEL_USER: loadPick = widen(userPowerRate);
				default: loadPick = widen(prevAvgPower);
			endcase
		end
	end

	// ****************************************
	// Next state
	// ****************************************
	assign accSum = st_r.chargeAccum + `ACC_W'(senseCharge);

	always_comb begin
		st_nxt = st_r;
		st_nxt.internalShort = shortDetect;
		st_nxt.tabDisconnect = tabLossDetect;
		st_nxt.loadFamily = loadMode;
		st_nxt.load = loadPick;
		// No-load compensation means a zero discharge rate for the reserve
		st_nxt.reserveRate = reserveRateSelectBit ? '0 : loadPick;
		if (senseValid) begin
			st_nxt.chargeAccum = accSum;
		end
		// Counted charge carries no load compensation
		st_nxt.nominalAvail = clampVal(st_r.chargeAccum);
		st_nxt.fullAvail = chemCapacity;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{internalShort: `RST_FLAG, tabDisconnect: `RST_FLAG,
				loadFamily: `FAMILY_CURRENT, load: `RST_LOAD, reserveRate: `RST_LOAD,
				chargeAccum: `RST_ACC, nominalAvail: `RST_VAL, fullAvail: `RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign internalShortFlag = st_r.internalShort;
	assign tabDisconnectFlag = st_r.tabDisconnect;
	assign loadFamilyStatusBit = st_r.loadFamily;
	assign selectedLoad = st_r.load;
	assign reserveCompRate = st_r.reserveRate;
	assign reserveChargeOut = reserveChargeAmount;
	assign chargeAccum = st_r.chargeAccum;
	assign nominalAvailValue = st_r.nominalAvail;
	assign fullAvailValue = st_r.fullAvail;

	always_comb begin
		flagsWord = '0;
		flagsWord[`FLAG_SOC_WARN_FINAL_FLAG_BIT] = socWarnFinalFlag;
		flagsWord[`FLAG_SOC_WARN_INITIAL_FLAG_BIT] = socWarnInitialFlag;
		flagsWord[`FLAG_TDD_BIT] = st_r.tabDisconnect;
		flagsWord[`FLAG_ISD_BIT] = st_r.internalShort;
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_soc1Set;
		@(posedge clk) disable iff (!rst_n)
		remUpdate && (remainingChargeValue < soc1SetThr) |=> socWarnInitialFlag;
	endproperty
	a_soc1Set: assert property (p_soc1Set) else $error("initial warning not set");

	property p_soc1Clear;
		@(posedge clk) disable iff (!rst_n)
		remUpdate && socWarnInitialFlag && (remainingChargeValue > soc1ClearThr)
			&& !(remainingChargeValue < soc1SetThr) |=> !socWarnInitialFlag;
	endproperty
	a_soc1Clear: assert property (p_soc1Clear) else $error("initial warning not cleared");

	property p_socfSet;
		@(posedge clk) disable iff (!rst_n)
		remUpdate && (socfSetThr != $signed(`SOC_WARN_FINAL_FLAG_SET_OFF))
			&& (remainingChargeValue < socfSetThr) |=> socWarnFinalFlag;
	endproperty
	a_socfSet: assert property (p_socfSet) else $error("final warning not set");

	property p_socfOff;
		@(posedge clk) disable iff (!rst_n)
		!socWarnFinalFlag && (socfSetThr == $signed(`SOC_WARN_FINAL_FLAG_SET_OFF)) |=> !socWarnFinalFlag;
	endproperty
	a_socfOff: assert property (p_socfOff) else $error("final warning set while off");

	property p_socfClear;
		@(posedge clk) disable iff (!rst_n)
		remUpdate && socWarnFinalFlag && (remainingChargeValue > socfClearThr)
			&& !(remainingChargeValue < socfSetThr) |=> !socWarnFinalFlag;
	endproperty
	a_socfClear: assert property (p_socfClear) else $error("final warning not cleared");

	property p_shortFlag;
		@(posedge clk) disable iff (!rst_n)
		shortDetect ##1 1'b1 |-> internalShortFlag && flagsWord[`FLAG_ISD_BIT];
	endproperty
	a_shortFlag: assert property (p_shortFlag) else $error("short flag missing");

	property p_tabFlag;
		@(posedge clk) disable iff (!rst_n)
		tabLossDetect |=> tabDisconnectFlag && flagsWord[`FLAG_TDD_BIT];
	endproperty
	a_tabFlag: assert property (p_tabFlag) else $error("tab flag missing");

	property p_reserveRate;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> reserveCompRate == ($past(reserveRateSelectBit) ? '0 : selectedLoad);
	endproperty
	a_reserveRate: assert property (p_reserveRate) else $error("reserve rate wrong");

	property p_fullAvail;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> fullAvailValue == $past(chemCapacity);
	endproperty
	a_fullAvail: assert property (p_fullAvail) else $error("full avail wrong");

	property p_familyMirror;
		@(posedge clk) disable iff (!rst_n)
		$changed(loadMode) |=> loadFamilyStatusBit == $past(loadMode);
	endproperty
	a_familyMirror: assert property (p_familyMirror) else $error("family bit stale");

	property p_overrideLoad;
		@(posedge clk) disable iff (!rst_n)
		(loadSelect == `LSEL_OVERRIDE) |=> selectedLoad == widen($past(rateOverrideValue));
	endproperty
	a_overrideLoad: assert property (p_overrideLoad) else $error("override load wrong");

	property p_accumulate;
		@(posedge clk) disable iff (!rst_n)
		senseValid |=> chargeAccum == $past(chargeAccum) + `ACC_W'($past(senseCharge));
	endproperty
	a_accumulate: assert property (p_accumulate) else $error("charge not accumulated");

	property p_holdNoUpdate;
		@(posedge clk) disable iff (!rst_n)
		!remUpdate |=> $stable(socWarnInitialFlag) && $stable(socWarnFinalFlag);
	endproperty
	a_holdNoUpdate: assert property (p_holdNoUpdate) else $error("flag moved without update");

endmodule : capacity_flags_load_model

// file: dv/gauge_host_model.sv
/*
 * Host side of the gauge: reads the flags word and load family bit.
 * Assumes the gauge clock and reset; a read request is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "capacity_flags_defs.svh"

module gauge_host_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic readReq,
	input wire logic [`FLAGS_W-1:0] flagsWord,
	input wire logic loadFamilyStatusBit,
	output logic [`FLAGS_W:0] readData
);
	// ****************************************
	// Status read
	// ****************************************
	// Holds the last read; the host only looks after its own request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readData <= '0;
		end else if (readReq) begin
			readData <= {loadFamilyStatusBit, flagsWord};
		end
	end
endmodule : gauge_host_model

// file: dv/capacity_flags_load_model_tb.sv
/*
 * Self-checking bench of the capacity flags and load model block.
 * Assumes the package and defs header compiled first; one 100 MHz clock.
 */
`timescale 1ns/1ps
`include "capacity_flags_defs.svh"

module capacity_flags_load_model_tb;
	import capacity_flags_pkg::*;
	logic clk, rst_n, remUpdate, shortDetect, tabLossDetect, loadMode, meanUpdate;
	logic reserveRateSelectBit, senseValid, readReq, mInit, mFinal, mShort, mTab;
	logic [2:0] loadSelect;
	logic signed [`VAL_W-1:0] remainingChargeValue, soc1SetThr, soc1ClearThr, socfSetThr;
	logic signed [`VAL_W-1:0] socfClearThr, prevAvgCurrent, presentAvgCurrent;
	logic signed [`VAL_W-1:0] meanCurrentValue, prevAvgPower, presentAvgPower;
	logic signed [`VAL_W-1:0] rateOverrideValue, userCurrentRate, userPowerRate, senseCharge;
	logic [`VAL_W-1:0] voltage, designCapacity, designEnergy, reserveChargeAmount, chemCapacity;
	logic socWarnInitialFlag, socWarnFinalFlag, internalShortFlag, tabDisconnectFlag;
	logic loadFamilyStatusBit;
	logic [`FLAGS_W-1:0] flagsWord;
	logic [`FLAGS_W:0] hostWord;
	logic signed [`LOAD_W-1:0] selectedLoad, reserveCompRate;
	logic signed [`ACC_W-1:0] chargeAccum;
	logic [`VAL_W-1:0] reserveChargeOut, nominalAvailValue, fullAvailValue;
	logic [15:0] rnd;
	int failCount, samplesChecked, lvl, acc, expLoad;

	capacity_flags_load_model dut_u (.clk(clk), .rst_n(rst_n), .remUpdate(remUpdate),
		.remainingChargeValue(remainingChargeValue), .soc1SetThr(soc1SetThr),
		.soc1ClearThr(soc1ClearThr), .socfSetThr(socfSetThr), .socfClearThr(socfClearThr),
		.shortDetect(shortDetect), .tabLossDetect(tabLossDetect), .loadMode(loadMode),
		.loadSelect(loadSelect), .prevAvgCurrent(prevAvgCurrent),
		.presentAvgCurrent(presentAvgCurrent), .meanUpdate(meanUpdate),
		.meanCurrentValue(meanCurrentValue), .voltage(voltage), .prevAvgPower(prevAvgPower),
		.presentAvgPower(presentAvgPower), .designCapacity(designCapacity),
		.designEnergy(designEnergy), .rateOverrideValue(rateOverrideValue),
		.userCurrentRate(userCurrentRate), .userPowerRate(userPowerRate),
		.reserveRateSelectBit(reserveRateSelectBit), .reserveChargeAmount(reserveChargeAmount),
		.senseValid(senseValid), .senseCharge(senseCharge), .chemCapacity(chemCapacity),
		.socWarnInitialFlag(socWarnInitialFlag), .socWarnFinalFlag(socWarnFinalFlag),
		.internalShortFlag(internalShortFlag), .tabDisconnectFlag(tabDisconnectFlag),
		.flagsWord(flagsWord), .loadFamilyStatusBit(loadFamilyStatusBit),
		.selectedLoad(selectedLoad), .reserveCompRate(reserveCompRate),
		.reserveChargeOut(reserveChargeOut), .chargeAccum(chargeAccum),
		.nominalAvailValue(nominalAvailValue), .fullAvailValue(fullAvailValue));

	gauge_host_model host_u (.clk(clk), .rst_n(rst_n), .readReq(readReq),
		.flagsWord(flagsWord), .loadFamilyStatusBit(loadFamilyStatusBit), .readData(hostWord));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] nextRand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nextRand

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samplesChecked++;
		if (got !== exp) begin
			failCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic conclude();
		if (failCount == 0 && samplesChecked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	// Flags seen directly and through a host read, one cycle spent
	task automatic chkFlags();
		chk("initial flag", 32'(mInit), 32'(socWarnInitialFlag));
		chk("final flag", 32'(mFinal), 32'(socWarnFinalFlag));
		chk("short flag", 32'(mShort), 32'(internalShortFlag));
		chk("tab flag", 32'(mTab), 32'(tabDisconnectFlag));
		chk("flags word", 32'({mShort, mTab, mInit, mFinal}), 32'(flagsWord));
		readReq = 1'h1;
		@(negedge clk);
		readReq = 1'h0;
		chk("host word", 32'({loadMode, mShort, mTab, mInit, mFinal}), 32'(hostWord));
	endtask : chkFlags

	task automatic remUpd(input logic signed [15:0] v);
		remainingChargeValue = v;
		remUpdate = 1'h1;
		@(negedge clk);
		remUpdate = 1'h0;
		if (int'(v) < int'(soc1SetThr)) mInit = 1'h1;
		else if (mInit && int'(v) > int'(soc1ClearThr)) mInit = 1'h0;
		if (socfSetThr !== `SOC_WARN_FINAL_FLAG_SET_OFF && int'(v) < int'(socfSetThr)) mFinal = 1'h1;
		else if (mFinal && int'(v) > int'(socfClearThr)) mFinal = 1'h0;
		chkFlags();
	endtask : remUpd

	function automatic int loadExp(input int m, input int s);
		int k;
		k = (s == 7) ? (m == 1 ? 0 : 1) : s;
		case (k)
			0: return m ? int'(prevAvgPower) : int'(prevAvgCurrent);
			1: return m ? int'(presentAvgPower) : int'(presentAvgCurrent);
			2: return m ? int'(meanCurrentValue) * int'(voltage) : int'(meanCurrentValue);
			3: return m ? lvl * int'(voltage) : lvl;
			4: return m ? int'(designEnergy) / 5 : int'(designCapacity) / 5;
			5: return int'(rateOverrideValue);
			default: return m ? int'(userPowerRate) : int'(userCurrentRate);
		endcase
	endfunction : loadExp

	// ****************************************
	// Clock, watchdog
	// ****************************************
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		failCount++;
		conclude();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_n = 1'h0;
		{remUpdate, shortDetect, tabLossDetect, loadMode, meanUpdate} = '0;
		{reserveRateSelectBit, senseValid, readReq, loadSelect} = '0;
		{mInit, mFinal, mShort, mTab} = '0;
		remainingChargeValue = 16'h01f4;
		soc1SetThr = 16'h0064;
		soc1ClearThr = 16'h00c8;
		socfSetThr = 16'h0032;
		socfClearThr = 16'h0064;
		prevAvgCurrent = -16'sd300;
		presentAvgCurrent = -16'sd250;
		meanCurrentValue = 16'h03e8;
		prevAvgPower = -16'sd900;
		presentAvgPower = 16'h0320;
		voltage = 16'h3000;
		designCapacity = 16'h1389;
		designEnergy = 16'hc351;
		rateOverrideValue = 16'h0000;
		userCurrentRate = 16'h0123;
		userPowerRate = -16'sd77;
		reserveChargeAmount = 16'h0040;
		senseCharge = 16'h0000;
		chemCapacity = 16'h2710;
		rnd = 16'h005f;
		failCount = 0;
		samplesChecked = 0;
		lvl = 0;
		acc = 0;
		repeat (16) @(negedge clk);
		rst_n = 1'h1;
		chkFlags();
		// Boundaries: equal values hold, clear needs strictly above
		remUpd(16'sd150);
		remUpd(16'sd99);
		remUpd(16'sd100);
		remUpd(16'sd200);
		remUpd(16'sd201);
		remUpd(16'sd49);
		remUpd(16'sd50);
		remUpd(16'sd100);
		remUpd(16'sd101);
		remUpd(16'sd60);
		remUpd(16'sd300);
		for (int i = 0; i < 24; i++) begin
			rnd = nextRand(rnd);
			remUpd(16'(int'(rnd[8:0]) - 20));
		end
		remUpd(16'sd300);
		// Value moves without a strobe: flags must not follow
		remainingChargeValue = 16'sd10;
		repeat (3) @(negedge clk);
		chkFlags();
		socfSetThr = `SOC_WARN_FINAL_FLAG_SET_OFF;
		remUpd(-16'sd5);
		remUpd(16'sd10);
		socfSetThr = 16'h0032;
		for (int i = 1; i < 5; i++) begin
			{tabLossDetect, shortDetect} = 2'(i);
			@(negedge clk);
			{mTab, mShort} = 2'(i);
			chkFlags();
		end
		// Five filter samples of a constant mean
		meanUpdate = 1'h1;
		for (int i = 0; i < 5; i++) begin
			@(negedge clk);
			lvl = lvl + (1000 - lvl) / 14;
		end
		meanUpdate = 1'h0;
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 8; s++) begin
				rnd = nextRand(rnd);
				rateOverrideValue = rnd;
				loadMode = m[0];
				loadSelect = s[2:0];
				reserveRateSelectBit = rnd[0];
				repeat (2) @(negedge clk);
				expLoad = loadExp(m, s);
				chk("selected load", expLoad, selectedLoad);
				chk("reserve rate", rnd[0] ? 0 : expLoad, reserveCompRate);
				chk("family bit", 32'(m), 32'(loadFamilyStatusBit));
			end
		end
		chk("reserve amount", 32'h00000040, 32'(reserveChargeOut));
		for (int i = 0; i < 14; i++) begin
			rnd = nextRand(rnd);
			senseCharge = (i == 0) ? -16'sd500 : $signed(rnd) >>> 3;
			chemCapacity = rnd;
			senseValid = 1'h1;
			acc = acc + int'(senseCharge);
			@(negedge clk);
			senseValid = (i > 10);
			chk("charge accum", acc, chargeAccum);
			if (i > 10) continue;
			@(negedge clk);
			chk("nominal avail", acc < 0 ? 0 : (acc > 65535 ? 65535 : acc),
				32'(nominalAvailValue));
			chk("full avail", 32'(rnd), 32'(fullAvailValue));
		end
		senseValid = 1'h0;
		conclude();
	end
endmodule : capacity_flags_load_model_tb
